// ===== design/ddcfs_top.sv
`timescale 1ns/1ps

module ddcfs_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire do_wr = wr_valid && wr_ready;
    wire do_rd = rd_valid && rd_ready;

    // honest flags straight from the occupancy count
    assign wr_ready = (cnt_r != (PW+1)'(DEPTH));
    assign rd_valid = (cnt_r != '0);
    assign rd_data = mem[rp_r];
    assign count = cnt_r;

    // pointers wrap at DEPTH so non power of two depths also work
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end

    // storage has no reset; only valid words are ever read
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wp_r] <= wr_data;
        end
    end
endmodule

module ddcfs_top import ddcfs_pkg::*; #(
    parameter int FIFO_DEPTH = DDCFS_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [DDCFS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic in_valid,
    output logic in_ready,
    input wire ddcfs_iq_t in_iq,
    input wire logic align_in,
    output logic out_valid,
    input wire logic out_ready,
    output ddcfs_word_t out_word
);
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
    localparam logic signed [DDCFS_DW-1:0] SMAX = {1'b0, {(DDCFS_DW-1){1'b1}}};
    localparam logic signed [DDCFS_DW-1:0] SMIN = {1'b1, {(DDCFS_DW-1){1'b0}}};
    localparam logic signed [DDCFS_ACC_W-1:0] RND = DDCFS_ACC_W'(1) <<< (DDCFS_FRAC - 1);

    // ------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------
    // folded dot product: pre-add mirrored taps, one multiply per pair
    function automatic logic signed [DDCFS_ACC_W-1:0] fir_dot(input ddcfs_taps_t t);
        logic signed [DDCFS_ACC_W-1:0] acc;
        logic signed [DDCFS_ACC_W-1:0] pre;
        acc = '0;
        for (int k = 0; k < DDCFS_HALF; k++) begin
            pre = DDCFS_ACC_W'($signed(t[k])) + DDCFS_ACC_W'($signed(t[DDCFS_TAPS-1-k]));
            acc = acc + pre * DDCFS_ACC_W'(DDCFS_COEF[k]);
        end
        return acc;
    endfunction

    // round half up, then clamp to the sample width
    function automatic logic [DDCFS_DW-1:0] sat_round(input logic signed [DDCFS_ACC_W-1:0] a);
        logic signed [DDCFS_ACC_W-1:0] s;
        s = (a + RND) >>> DDCFS_FRAC;
        if (s > DDCFS_ACC_W'(SMAX)) begin
            return SMAX;
        end else if (s < DDCFS_ACC_W'(SMIN)) begin
            return SMIN;
        end
        return s[DDCFS_DW-1:0];
    endfunction

    // negation that cannot wrap the most negative code
    function automatic logic [DDCFS_DW-1:0] neg_sat(input logic [DDCFS_DW-1:0] v);
        return (v == SMIN) ? SMAX : DDCFS_DW'(-$signed(v));
    endfunction

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0] sync_cfg_r;
    logic [7:0] fir_cfg_r;
    logic [7:0] hb_cfg_r;
    logic [7:0] shift_cfg_r;
    logic armed_r;
    logic [CNT_W-1:0] fifo_cnt;
    wire bus_req = avs_read || avs_write;
    wire bus_go = bus_req && !wait_r;
    wire wr_go = bus_go && avs_write;
    wire hit_sync = (avs_address == DDCFS_ADR_SYNC);
    wire hit_fir = (avs_address == DDCFS_ADR_FIR);
    wire hit_hb = (avs_address == DDCFS_ADR_HB);
    wire hit_shift = (avs_address == DDCFS_ADR_SHIFT);
    wire hit_stat = (avs_address == DDCFS_ADR_STAT);
    wire sync_wr = wr_go && hit_sync;
    // the half-band cannot be turned off, so the fir gate is only its enable
    wire hb_on = 1'b1;
    wire fir_act = fir_cfg_r[DDCFS_BIT_FIR_EN] && hb_on;
    wire rs_en = sync_cfg_r[DDCFS_BIT_RS_EN];
    wire rs_once = sync_cfg_r[DDCFS_BIT_RS_ONCE];
    wire dec_phase = hb_cfg_r[DDCFS_BIT_PHASE];
    wire shift_en = shift_cfg_r[DDCFS_BIT_SHIFT_EN];
    wire [7:0] stat_val = {fifo_cnt[3:0], 2'h0, armed_r, fir_act};
    wire [7:0] rd_mux = hit_sync ? sync_cfg_r :
                        hit_fir ? fir_cfg_r :
                        hit_hb ? hb_cfg_r :
                        hit_shift ? shift_cfg_r :
                        hit_stat ? stat_val : 8'h00;

    // one wait state: data is registered while waitrequest is still high
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(bus_req && wait_r);
            rdata_r <= {24'h00_0000, rd_mux};
        end
    end

    // configuration writes only on the accepting edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_cfg_r <= DDCFS_RST_SYNC;
            fir_cfg_r <= DDCFS_RST_FIR;
            hb_cfg_r <= DDCFS_RST_HB;
            shift_cfg_r <= DDCFS_RST_SHIFT;
        end else if (wr_go) begin
            if (hit_sync) sync_cfg_r <= avs_writedata[7:0];
            if (hit_fir) fir_cfg_r <= avs_writedata[7:0];
            if (hit_hb) hb_cfg_r <= avs_writedata[7:0];
            if (hit_shift) shift_cfg_r <= avs_writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // alignment input and half-band phase
    // ------------------------------------------------------------
    logic al_m_r;
    logic al_s_r;
    logic al_d_r;
    logic hb_cnt_r;
    logic in_ready_r;
    wire al_rise = al_s_r && !al_d_r;
    wire sync_acc = al_rise && rs_en && (!rs_once || armed_r);
    wire in_take = in_valid && in_ready_r;
    wire hb_keep = in_take && !sync_acc && (hb_cnt_r == dec_phase);

    // two-flop synchroniser, edge found after the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            al_m_r <= 1'b0;
            al_s_r <= 1'b0;
            al_d_r <= 1'b0;
        end else begin
            al_m_r <= align_in;
            al_s_r <= al_m_r;
            al_d_r <= al_s_r;
        end
    end

    // a register write re-arms and wins over a pulse in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (sync_wr) begin
            armed_r <= 1'b1;
        end else if (sync_acc && rs_once) begin
            armed_r <= 1'b0;
        end
    end

    // accepted alignment restarts the two-sample decimation count
    always_ff @(posedge clk_sys) begin
        if (rst || sync_acc) begin
            hb_cnt_r <= 1'b0;
        end else if (in_take) begin
            hb_cnt_r <= !hb_cnt_r;
        end
    end

    // ------------------------------------------------------------
    // fir pipeline: delay line, dot product, round
    // ------------------------------------------------------------
    ddcfs_taps_t dl_i_r;
    ddcfs_taps_t dl_q_r;
    logic st1_v_r;
    logic st2_v_r;
    logic st2_fir_r;
    logic signed [DDCFS_ACC_W-1:0] acc_i_r;
    logic signed [DDCFS_ACC_W-1:0] acc_q_r;
    ddcfs_iq_t byp_r;
    ddcfs_iq_t rs_r;
    logic rs_v_r;

    // delay lines move once per kept half-band sample, newest at index 0
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dl_i_r <= '0;
            dl_q_r <= '0;
        end else if (hb_keep) begin
            dl_i_r <= {dl_i_r[DDCFS_TAPS-2:0], in_iq.i};
            dl_q_r <= {dl_q_r[DDCFS_TAPS-2:0], in_iq.q};
        end
    end

    // bypass rides the same stages so latency never depends on the mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st1_v_r <= 1'b0;
            st2_v_r <= 1'b0;
            st2_fir_r <= 1'b0;
            acc_i_r <= '0;
            acc_q_r <= '0;
            byp_r <= '0;
        end else begin
            st1_v_r <= hb_keep;
            st2_v_r <= st1_v_r;
            st2_fir_r <= fir_act;
            acc_i_r <= fir_dot(dl_i_r);
            acc_q_r <= fir_dot(dl_q_r);
            byp_r <= {dl_i_r[0], dl_q_r[0]};
        end
    end

    // mode is frozen per sample at stage two
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rs_r <= '0;
            rs_v_r <= 1'b0;
        end else begin
            rs_v_r <= st2_v_r;
            rs_r.i <= st2_fir_r ? sat_round(acc_i_r) : byp_r.i;
            rs_r.q <= st2_fir_r ? sat_round(acc_q_r) : byp_r.q;
        end
    end

    // ------------------------------------------------------------
    // final shift and word emission
    // ------------------------------------------------------------
    ddcfs_emit_t em_r;
    ddcfs_emit_t em_nxt;
    logic [1:0] rot_r;
    logic [DDCFS_DW-1:0] q_hold_r;
    logic [DDCFS_DW-1:0] shift_val;
    logic wr_v;
    ddcfs_word_t wr_word;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    ddcfs_word_t fifo_rd_data;
    logic out_valid_r;
    ddcfs_word_t out_word_r;
    wire fifo_rd_ready = !out_valid_r || out_ready;

    // real part of the sample times j^n: quarter turn per output sample
    assign shift_val = (rot_r == 2'h0) ? rs_r.i :
                       (rot_r == 2'h1) ? neg_sat(rs_r.q) :
                       (rot_r == 2'h2) ? neg_sat(rs_r.i) : rs_r.q;

    // samples are at least two cycles apart, so the q slot is always free
    always_comb begin
        em_nxt = em_r;
        wr_v = 1'b0;
        wr_word = '0;
        case (em_r)
            DDCFS_EM_I: begin
                if (rs_v_r && shift_en) begin
                    wr_v = 1'b1;
                    wr_word = {1'b0, shift_val};
                end else if (rs_v_r) begin
                    wr_v = 1'b1;
                    wr_word = {1'b0, rs_r.i};
                    em_nxt = DDCFS_EM_Q;
                end
            end
            DDCFS_EM_Q: begin
                wr_v = 1'b1;
                wr_word = {1'b1, q_hold_r};
                em_nxt = DDCFS_EM_I;
            end
            default: begin
                em_nxt = DDCFS_EM_I;
            end
        endcase
    end

    // rotation advances only on shifted samples
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            em_r <= DDCFS_EM_I;
            rot_r <= 2'h0;
            q_hold_r <= '0;
        end else begin
            em_r <= em_nxt;
            if (rs_v_r && shift_en) rot_r <= rot_r + 2'h1;
            if (rs_v_r) q_hold_r <= rs_r.q;
        end
    end

    ddcfs_fifo #(
        .W($bits(ddcfs_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_valid(wr_v),
        .wr_ready(fifo_wr_ready),
        .wr_data(wr_word),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready),
        .rd_data(fifo_rd_data),
        .count(fifo_cnt)
    );

    // input stalls early enough to cover every word still in the pipe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
            out_word_r <= '0;
        end else begin
            in_ready_r <= (fifo_cnt <= CNT_W'(FIFO_DEPTH - DDCFS_HEADROOM));
            if (fifo_rd_ready) begin
                out_valid_r <= fifo_rd_valid;
                if (fifo_rd_valid) out_word_r <= fifo_rd_data;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_word = out_word_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_NO_DECIM: assert property (hb_keep |-> ##3 rs_v_r)
        else $error("kept sample did not leave the fir");
    AST_BYPASS: assert property (hb_keep && !fir_act ##1 !fir_act
            |-> ##2 rs_r == $past(in_iq, 3))
        else $error("bypass did not pass the sample unchanged");
    AST_FIR_ON: assert property (st2_v_r && st2_fir_r
            |=> rs_r.i == sat_round($past(acc_i_r)))
        else $error("fir result not rounded from sum");
    // phase 0 keeps the very next sample, so only the pulse cycle itself is dropped
    AST_RESYNC: assert property (sync_acc |-> !hb_keep ##1 hb_cnt_r == 1'b0)
        else $error("alignment did not restart decimation");
    AST_ONESHOT: assert property (sync_acc && rs_once && !sync_wr
            |=> !armed_r ##1 !sync_acc)
        else $error("one-shot resync did not disarm");
    AST_PHASE: assert property (in_take && !sync_acc && hb_cnt_r == dec_phase
            |=> st1_v_r)
        else $error("decimation phase not honoured");
    AST_SHIFT: assert property (rs_v_r && shift_en && rot_r == 2'h2
            && em_r == DDCFS_EM_I |-> wr_v && wr_word.data == neg_sat(rs_r.i))
        else $error("final shift produced wrong real value");
    AST_INTERLEAVE: assert property (rs_v_r && !shift_en && em_r == DDCFS_EM_I
            |-> !wr_word.is_q ##1 wr_v && wr_word.is_q && wr_word.data == $past(rs_r.q))
        else $error("q word did not follow i word");
    AST_NO_OVF: assert property (wr_v |-> fifo_wr_ready)
        else $error("word pushed into a full buffer");
    // any sum past this bound rounds above the largest sample
    AST_SAT: assert property (st2_v_r && st2_fir_r
            && acc_i_r > (DDCFS_ACC_W'(SMAX) <<< DDCFS_FRAC) + RND |=> rs_r.i == SMAX)
        else $error("positive overflow not saturated");

    COV_FIR_SAMPLE: cover property (st2_v_r && st2_fir_r ##1 rs_v_r);
    COV_SHIFT_WRAP: cover property (rs_v_r && shift_en && rot_r == 2'h3);
    COV_ONESHOT: cover property (sync_acc && rs_once ##[1:50] al_rise && !sync_acc);
    COV_BACKPRESSURE: cover property (!in_ready_r && in_valid);
endmodule

// ===== design/ddcfs_pkg.sv
package ddcfs_pkg;

    // ------------------------------------------------------------
    // datapath widths and filter shape
    // ------------------------------------------------------------
    localparam int DDCFS_DW = 16;
    localparam int DDCFS_CW = 21;
    localparam int DDCFS_TAPS = 66;
    localparam int DDCFS_HALF = 33;
    localparam int DDCFS_ACC_W = 44;
    localparam int DDCFS_FRAC = 21;
    localparam int DDCFS_AW = 14;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] DDCFS_IDX_SYNC = 12'h100;
    localparam logic [11:0] DDCFS_IDX_FIR = 12'h102;
    localparam logic [11:0] DDCFS_IDX_HB = 12'h103;
    localparam logic [11:0] DDCFS_IDX_SHIFT = 12'h110;
    localparam logic [11:0] DDCFS_IDX_STAT = 12'h111;
    localparam logic [13:0] DDCFS_ADR_SYNC = {DDCFS_IDX_SYNC, 2'h0};
    localparam logic [13:0] DDCFS_ADR_FIR = {DDCFS_IDX_FIR, 2'h0};
    localparam logic [13:0] DDCFS_ADR_HB = {DDCFS_IDX_HB, 2'h0};
    localparam logic [13:0] DDCFS_ADR_SHIFT = {DDCFS_IDX_SHIFT, 2'h0};
    localparam logic [13:0] DDCFS_ADR_STAT = {DDCFS_IDX_STAT, 2'h0};

    // ------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------
    localparam int DDCFS_BIT_FIR_EN = 0;
    localparam int DDCFS_BIT_RS_EN = 5;
    localparam int DDCFS_BIT_RS_ONCE = 6;
    localparam int DDCFS_BIT_PHASE = 3;
    localparam int DDCFS_BIT_SHIFT_EN = 0;
    localparam logic [7:0] DDCFS_RST_SYNC = 8'h00;
    localparam logic [7:0] DDCFS_RST_FIR = 8'h00;
    localparam logic [7:0] DDCFS_RST_HB = 8'h00;
    localparam logic [7:0] DDCFS_RST_SHIFT = 8'h00;

    // ------------------------------------------------------------
    // buffering
    // ------------------------------------------------------------
    localparam int DDCFS_FIFO_DEPTH = 8;
    localparam int DDCFS_HEADROOM = 6;

    // ------------------------------------------------------------
    // first half of the symmetric coefficient table, tap 0 first
    // ------------------------------------------------------------
    localparam logic signed [DDCFS_CW-1:0] DDCFS_COEF [DDCFS_HALF] = '{
        21'sd383, 21'sd1431, 21'sd1950, 21'sd96, -21'sd2661, -21'sd1750,
        21'sd2476, 21'sd2388, -21'sd3867, -21'sd5150, 21'sd3788, 21'sd7513,
        -21'sd4511, -21'sd11914, 21'sd3650, 21'sd16484, -21'sd2818, -21'sd23200,
        -21'sd48, 21'sd30748, 21'sd3976, -21'sd41019, -21'sd11147, 21'sd53608,
        21'sd21818, -21'sd71611, -21'sd40300, 21'sd98830, 21'sd74264,
        -21'sd152696, -21'sd161248, 21'sd337056, 21'sd922060};

    // ------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DDCFS_DW-1:0] i;
        logic [DDCFS_DW-1:0] q;
    } ddcfs_iq_t;

    typedef struct packed {
        logic is_q;
        logic [DDCFS_DW-1:0] data;
    } ddcfs_word_t;

    typedef logic [DDCFS_TAPS-1:0][DDCFS_DW-1:0] ddcfs_taps_t;

    typedef enum logic {
        DDCFS_EM_I = 1'b0,
        DDCFS_EM_Q = 1'b1
    } ddcfs_emit_t;

endpackage

// ===== sim/ddcfs_sink.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// capture logic on the far side of the output stream
// ------------------------------------------------------------
module ddcfs_sink import ddcfs_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    input wire logic out_valid,
    output logic out_ready,
    input wire ddcfs_word_t out_word
);
    ddcfs_word_t got[$];
    logic tick_r;

    // stall holds ready low; slow mode takes one word every other cycle
    assign out_ready = !stall && !(slow && tick_r);

    // record words in arrival order so the bench can check interleaving
    always @(posedge clk_sys) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= !tick_r;
            if (out_valid && out_ready) begin
                got.push_back(out_word);
            end
        end
    end
endmodule

// ===== sim/ddcfs_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (a), (b)); end end

module ddcfs_top_tb_top import ddcfs_pkg::*; ();
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic in_valid, in_ready, align_in, out_valid, out_ready, stall, slow;
    ddcfs_iq_t in_iq;
    ddcfs_word_t out_word;
    ddcfs_word_t exp_q[$];
    int n_mismatch, comparisons, cnt, ph, rot, k;
    bit shift_on, track, ok;

    ddcfs_top ddcfs_top_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .in_valid(in_valid), .in_ready(in_ready), .in_iq(in_iq), .align_in(align_in),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
    ddcfs_sink ddcfs_sink_inst (.clk_sys(clk_sys), .rst(rst), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));

    // ------------------------------------------------------------
    // clock, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end

    // the whole run needs about a thousand cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus, stream and alignment drivers
    // ------------------------------------------------------------
    // an idle edge before each request keeps the strobes single-assigned
    task automatic bus(input bit wr, input logic [13:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic chk_reg(input logic [13:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    function automatic logic [15:0] neg(input logic [15:0] x);
        return (x == 16'h8000) ? 16'h7FFF : 16'h0 - x;
    endfunction

    // expected words are produced here as each kept sample is taken, while tracking is on
    task automatic send(input logic [15:0] i, input logic [15:0] q);
        int w;
        in_iq <= '{i: i, q: q};
        in_valid <= 1'b1;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (in_ready !== 1'b1 && w < 20);
        ok = (in_ready === 1'b1);
        if (!ok) begin
            in_valid <= 1'b0;
        end else begin
            // the rotation turns on every shifted sample, tracked or not
            if (cnt == ph && shift_on) begin
                if (track) begin
                    exp_q.push_back({1'b0, rot == 0 ? i : rot == 1 ? neg(q) :
                                     rot == 2 ? neg(i) : q});
                end
                rot = (rot + 1) % 4;
            end else if (track && cnt == ph) begin
                exp_q.push_back({1'b0, i});
                exp_q.push_back({1'b1, q});
            end
            cnt ^= 1;
        end
    endtask

    task automatic idle();
        in_valid <= 1'b0;
    endtask

    task automatic pulse();
        align_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        align_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    // waits a bounded time for the expected words, then compares them in order
    task automatic drain_check();
        int w;
        for (w = 0; w < 2000 && ddcfs_sink_inst.got.size() < exp_q.size(); w++) begin
            @(posedge clk_sys);
        end
        repeat (20) @(posedge clk_sys);
        `CHK(ddcfs_sink_inst.got.size(), exp_q.size())
        for (w = 0; w < exp_q.size() && w < ddcfs_sink_inst.got.size(); w++) begin
            `CHK(ddcfs_sink_inst.got[w], exp_q[w])
        end
        exp_q.delete();
        ddcfs_sink_inst.got.delete();
    endtask

    function automatic logic [15:0] fir_exp(input longint x, input longint c);
        longint s;
        s = (x * c + 64'sd1048576) >>> 21;
        return (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : s[15:0];
    endfunction

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {rst, avs_read, avs_write, in_valid, align_in, stall, slow} = 7'b1000000;
        avs_address = 14'h0;
        avs_writedata = 32'h0;
        in_iq = '0;
        {n_mismatch, comparisons, cnt, ph, rot, shift_on, track} = '0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        chk_reg(DDCFS_ADR_SYNC, 32'h0);
        chk_reg(DDCFS_ADR_FIR, 32'h0);
        chk_reg(DDCFS_ADR_HB, 32'h0);
        chk_reg(DDCFS_ADR_SHIFT, 32'h0);
        bus(1'b1, 14'h0004, 32'hFF);
        chk_reg(14'h0004, 32'h0);
        // final shift: rotation through I, -Q, -I, Q with negation saturating
        bus(1'b1, DDCFS_ADR_SHIFT, 32'h01);
        {shift_on, track} = 2'b11;
        send(16'h1234, 16'h0567);
        send(16'hAAAA, 16'h5555);
        send(16'h2000, 16'h8000);
        send(16'hAAAA, 16'h5555);
        send(16'h8000, 16'h0100);
        send(16'hAAAA, 16'h5555);
        send(16'h0011, 16'h0022);
        send(16'hAAAA, 16'h5555);
        idle();
        drain_check();
        // shift bypassed: interleaved words, phase 0 then phase 1, slow consumer
        bus(1'b1, DDCFS_ADR_SHIFT, 32'h00);
        shift_on = 1'b0;
        slow <= 1'b1;
        for (k = 0; k < 6; k++) send(16'h1111 * k, 16'hF0F0 - k);
        idle();
        drain_check();
        bus(1'b1, DDCFS_ADR_HB, 32'h08);
        ph = 1;
        for (k = 0; k < 6; k++) send(16'h0101 * k, 16'h7000 + k);
        idle();
        drain_check();
        bus(1'b1, DDCFS_ADR_HB, 32'h00);
        ph = 0;
        // buffer fills while the consumer stalls, then drains without loss
        stall <= 1'b1;
        for (k = 0; k < 40; k++) begin
            send(16'h0200 + k, 16'h0300 + k);
            if (!ok) break;
        end
        repeat (10) @(posedge clk_sys);
        bus(1'b0, DDCFS_ADR_STAT, 32'h0);
        `CHK({rd[31:8], rd[3:0]}, 28'h0)
        `CHK(in_ready, 1'b0)
        `CHK(rd[7:4] > 4'h2 && rd[7:4] <= 4'h8, 1'b1)
        stall <= 1'b0;
        drain_check();
        // resync on every pulse: each accepted pulse restarts the phase count
        bus(1'b1, DDCFS_ADR_SYNC, 32'h20);
        send(16'h0A0A, 16'h0B0B);
        idle();
        pulse();
        cnt = 0;
        send(16'h0C0C, 16'h0D0D);
        idle();
        pulse();
        cnt = 0;
        send(16'h0E0E, 16'h0F0F);
        send(16'h1A1A, 16'h1B1B);
        idle();
        drain_check();
        // one-shot resync: armed by the write, disarmed by the first pulse
        bus(1'b1, DDCFS_ADR_SYNC, 32'h60);
        bus(1'b0, DDCFS_ADR_STAT, 32'h0);
        `CHK(rd[1], 1'b1)
        send(16'h2A2A, 16'h2B2B);
        idle();
        pulse();
        cnt = 0;
        bus(1'b0, DDCFS_ADR_STAT, 32'h0);
        `CHK(rd[1], 1'b0)
        send(16'h3A3A, 16'h3B3B);
        idle();
        pulse();
        send(16'h4A4A, 16'h4B4B);
        send(16'h5A5A, 16'h5B5B);
        idle();
        drain_check();
        // filter inserted: flush with zeros, then an impulse on both paths
        bus(1'b1, DDCFS_ADR_FIR, 32'h01);
        bus(1'b0, DDCFS_ADR_STAT, 32'h0);
        `CHK(rd[0], 1'b1)
        track = 0;
        for (k = 0; k < 140 + cnt; k++) send(16'h0, 16'h0);
        idle();
        repeat (60) @(posedge clk_sys);
        ddcfs_sink_inst.got.delete();
        send(16'h7FFF, 16'h8001);
        for (k = 0; k < 131; k++) send(16'h0, 16'h0);
        idle();
        for (k = 0; k < 3000 && ddcfs_sink_inst.got.size() < 132; k++) @(posedge clk_sys);
        `CHK(ddcfs_sink_inst.got.size() >= 132, 1'b1)
        for (k = 0; k < 66 && ddcfs_sink_inst.got.size() >= 132; k++) begin
            `CHK(ddcfs_sink_inst.got[2*k], ddcfs_sink_inst.got[2*(65-k)])
            `CHK(ddcfs_sink_inst.got[2*k+1].is_q, 1'b1)
        end
        `CHK(ddcfs_sink_inst.got[0], {1'b0, fir_exp(32767, 383)})
        `CHK(ddcfs_sink_inst.got[60], {1'b0, fir_exp(32767, -161248)})
        `CHK(ddcfs_sink_inst.got[64], {1'b0, fir_exp(32767, 922060)})
        `CHK(ddcfs_sink_inst.got[65], {1'b1, fir_exp(-32767, 922060)})
        `CHK(ddcfs_sink_inst.got[1], {1'b1, fir_exp(-32767, 383)})
        // real output with the filter kept in; this dc level passes at unity gain
        bus(1'b1, DDCFS_ADR_SHIFT, 32'h01);
        shift_on = 1'b1;
        for (k = 0; k < 140 + cnt; k++) send(16'h1000, 16'h0800);
        idle();
        repeat (60) @(posedge clk_sys);
        ddcfs_sink_inst.got.delete();
        track = 1'b1;
        for (k = 0; k < 8; k++) send(16'h1000, 16'h0800);
        idle();
        drain_check();
        conclude();
    end
endmodule
